// file: rtl/ata_sec_pkg.sv
/*
 * Shared constants and types for the task-file command block:
 * APB register offsets, command codes, field positions, reset values,
 * the controller state enum and the packed status carrier.
 * Assumes a 32-bit APB bus with one aligned word per register.
 */
package ata_sec_pkg;

    localparam int          ADDR_W          = 8;
    localparam logic [7:0]  OFS_COMMAND     = 8'h00;
    localparam logic [7:0]  OFS_LBA_LOW     = 8'h04;
    localparam logic [7:0]  OFS_LBA_MID     = 8'h08;
    localparam logic [7:0]  OFS_LBA_HIGH    = 8'h0c;
    localparam logic [7:0]  OFS_SECTOR_CNT  = 8'h10;
    localparam logic [7:0]  OFS_STATUS      = 8'h14;
    localparam logic [7:0]  OFS_DATA        = 8'h18;
    localparam logic [7:0]  OFS_CONFIG      = 8'h1c;

    localparam logic [7:0]  CMD_VERIFY_EXT  = 8'h42;
    localparam logic [3:0]  CMD_NOP_NIBBLE  = 4'h1;
    localparam logic [7:0]  CMD_SET_PW      = 8'hf1;
    localparam logic [7:0]  CMD_ERASE_PREP  = 8'hf3;
    localparam logic [7:0]  CMD_ERASE_UNIT  = 8'hf4;
    localparam logic [7:0]  CMD_FREEZE      = 8'hf5;
    localparam logic [7:0]  CMD_DISABLE_PW  = 8'hf6;

    localparam int          PW_WORDS        = 16;
    localparam int          SECTOR_WORDS    = 256;
    localparam int          CTRL_ID_BIT     = 0;
    localparam int          CTRL_LEVEL_BIT  = 8;
    localparam int          CFG_SEC_SUP_BIT = 0;
    localparam logic [16:0] VERIFY_MAX_CNT  = 17'h10000;
    localparam logic        CFG_SEC_SUP_RST = 1'b1;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_VREQ,
        ST_VWAIT,
        ST_DATA,
        ST_EXEC
    } ctl_state_e;

    // Read layout of the status register, bit 0 is err
    typedef struct packed {
        logic frozen;
        logic locked;
        logic user_pw_set;
        logic level_max;
        logic bsy;
        logic drq;
        logic err;
    } sec_status_s;

endpackage : ata_sec_pkg

// file: rtl/ata_verify_security_cmds.sv
/*
 * Task-file command interpreter: 48-bit read verify, recalibrate no-op and
 * the security commands (set/disable password, erase prepare/unit, freeze).
 * Assumes an APB master on pclk, and a media checker that answers each
 * sector_check_req pulse with one sector_check_done pulse.
 */
// Implementation choices: register access over APB and the register addresses.
// Overview of operation
// - Verify ext 42h sets busy, never raises data request, moves no data.
// - After all verify sectors pass, busy clears and interrupt rises.
// - Successful verify leaves last verified sector address in address registers.
// - Verify error stops at failing sector, its address stays in registers.
// - On verify error, sector count holds sectors not yet verified.
// - Any 1Xh command is a no-op completing without touching stored data.
// - Disable password takes one sector; matching password leaves lock mode.
// - Disable password keeps master password; a new user password revives it.
// - Sector word 0 bit 0 picks user/master, words 1-16 password.
// - Erase unit takes one sector; aborts on password mismatch.
// - Erase unit aborts unless previous command was erase prepare.
// - After freeze, set/disable password and erase unit are rejected.
// - Frozen lasts until reset; repeated freeze runs normally, stays frozen.
// - Completing freeze writes zero into the sector count register.
// - Without security support, the freeze code runs wear-level instead.
// - Set user password stores it and arms lock from next reset.
// - High level unlocks by user or master; maximum by user only.
// - Set master password stores it, leaving lock mode and level alone.
`timescale 1ns/1ps
`default_nettype none

module ata_verify_security_cmds
(
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          nv_init_n,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [ata_sec_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    output logic                               intrq,
    output logic                               sector_check_req,
    output logic      [47:0]                   sector_check_lba,
    input  wire logic                          sector_check_done,
    input  wire logic                          sector_check_bad,
    output logic                               erase_req,
    output logic                               wear_level_req
);

    ata_sec_pkg::ctl_state_e state;
    logic [15:0] lba_low;
    logic [15:0] lba_mid;
    logic [15:0] lba_high;
    logic [15:0] sector_count;
    logic [16:0] remain;
    logic [7:0]  cmd;
    logic [7:0]  widx;
    logic [15:0] ctrl_word;
    logic        err;
    logic        done_pulse;
    logic        prepared;
    logic        frozen;
    logic        locked;
    logic        rst_seen;
    logic        user_pw_set;
    logic        level_max;
    logic        sec_sup;
    logic [15:0] pw_buf    [ata_sec_pkg::PW_WORDS];
    logic [15:0] user_pw   [ata_sec_pkg::PW_WORDS];
    logic [15:0] master_pw [ata_sec_pkg::PW_WORDS];
    logic [ata_sec_pkg::PW_WORDS-1:0] user_eq;
    logic [ata_sec_pkg::PW_WORDS-1:0] master_eq;
    logic        wr;
    logic        rd;
    logic        cmd_go;
    logic [7:0]  code;
    logic        is_nop;
    logic        sec_cmd;
    logic        pre_abort;
    logic        pw_ok;
    logic        exec_ok;
    logic [47:0] lba;
    logic [47:0] next_lba;
    ata_sec_pkg::sec_status_s status;
    assign wr     = psel && penable && pready && pwrite;
    assign rd     = psel && penable && pready && !pwrite;
    assign code   = pwdata[7:0];
    assign cmd_go = wr && (paddr == ata_sec_pkg::OFS_COMMAND) && (state == ata_sec_pkg::ST_IDLE);
    assign is_nop = (code[7:4] == ata_sec_pkg::CMD_NOP_NIBBLE);
    assign sec_cmd = (code == ata_sec_pkg::CMD_SET_PW) || (code == ata_sec_pkg::CMD_ERASE_UNIT)
                     || (code == ata_sec_pkg::CMD_DISABLE_PW);
    assign pre_abort = !sec_sup || frozen
                       || ((code == ata_sec_pkg::CMD_ERASE_UNIT) && !prepared);
    assign lba = {lba_high[15:8], lba_mid[15:8], lba_low[15:8],
                  lba_high[7:0], lba_mid[7:0], lba_low[7:0]};
    assign next_lba = lba + 48'h1;
    generate
        for (genvar i = 0; i < ata_sec_pkg::PW_WORDS; i++)
        begin : g_cmp
            assign user_eq[i]   = (pw_buf[i] == user_pw[i]);
            assign master_eq[i] = (pw_buf[i] == master_pw[i]);
        end
    endgenerate
    // Master is refused at maximum level even if it matches
    assign pw_ok = ctrl_word[ata_sec_pkg::CTRL_ID_BIT]
                   ? (&master_eq && !level_max)
                   : &user_eq;
    assign exec_ok = (cmd == ata_sec_pkg::CMD_SET_PW) || pw_ok;
    assign status = '{frozen: frozen, locked: locked, user_pw_set: user_pw_set,
                      level_max: level_max,
                      bsy: (state != ata_sec_pkg::ST_IDLE) && (state != ata_sec_pkg::ST_DATA),
                      drq: (state == ata_sec_pkg::ST_DATA), err: err};
    // APB slave: one wait state so read data comes from a flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && (paddr > ata_sec_pkg::OFS_CONFIG);
            prdata  <= 32'h0000_0000;
            if (psel && penable && !pready && !pwrite)
            begin
                unique case (paddr)
                    ata_sec_pkg::OFS_COMMAND:    prdata <= {24'h00_0000, cmd};
                    ata_sec_pkg::OFS_LBA_LOW:    prdata <= {16'h0000, lba_low};
                    ata_sec_pkg::OFS_LBA_MID:    prdata <= {16'h0000, lba_mid};
                    ata_sec_pkg::OFS_LBA_HIGH:   prdata <= {16'h0000, lba_high};
                    ata_sec_pkg::OFS_SECTOR_CNT: prdata <= {16'h0000, sector_count};
                    ata_sec_pkg::OFS_STATUS:     prdata <= {25'h000_0000, status};
                    ata_sec_pkg::OFS_CONFIG:     prdata <= {31'h0000_0000, sec_sup};
                    default:                     prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Command sequencing, task-file registers and media verify loop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state            <= ata_sec_pkg::ST_IDLE;
            lba_low          <= 16'h0000;
            lba_mid          <= 16'h0000;
            lba_high         <= 16'h0000;
            sector_count     <= 16'h0000;
            remain           <= 17'h0_0000;
            cmd              <= 8'h00;
            widx             <= 8'h00;
            ctrl_word        <= 16'h0000;
            err              <= 1'b0;
            done_pulse       <= 1'b0;
            prepared         <= 1'b0;
            sector_check_req <= 1'b0;
            sector_check_lba <= 48'h0000_0000_0000;
            erase_req        <= 1'b0;
            wear_level_req   <= 1'b0;
        end
        else
        begin
            done_pulse       <= 1'b0;
            sector_check_req <= 1'b0;
            erase_req        <= 1'b0;
            wear_level_req   <= 1'b0;
            // Task-file register writes are dropped while busy so the host cannot corrupt a command
            if (wr && (state == ata_sec_pkg::ST_IDLE))
            begin
                unique case (paddr)
                    ata_sec_pkg::OFS_LBA_LOW:    lba_low      <= {lba_low[7:0], pwdata[7:0]};
                    ata_sec_pkg::OFS_LBA_MID:    lba_mid      <= {lba_mid[7:0], pwdata[7:0]};
                    ata_sec_pkg::OFS_LBA_HIGH:   lba_high     <= {lba_high[7:0], pwdata[7:0]};
                    ata_sec_pkg::OFS_SECTOR_CNT: sector_count <= {sector_count[7:0], pwdata[7:0]};
                    default:                     ;
                endcase
            end
            if (cmd_go)
            begin
                cmd      <= code;
                err      <= 1'b0;
                prepared <= (code == ata_sec_pkg::CMD_ERASE_PREP);
                if (code == ata_sec_pkg::CMD_VERIFY_EXT)
                begin
                    remain <= (sector_count == 16'h0000) ? ata_sec_pkg::VERIFY_MAX_CNT
                                                         : {1'b0, sector_count};
                    state  <= ata_sec_pkg::ST_VREQ;
                end
                else if (sec_cmd && !pre_abort)
                begin
                    widx  <= 8'h00;
                    state <= ata_sec_pkg::ST_DATA;
                end
                else
                begin
                    done_pulse <= 1'b1;
                    if (code == ata_sec_pkg::CMD_FREEZE)
                    begin
                        if (sec_sup)
                            sector_count <= 16'h0000;
                        else
                            wear_level_req <= 1'b1;
                    end
                    else if (!is_nop && (code != ata_sec_pkg::CMD_ERASE_PREP))
                        err <= 1'b1;
                end
            end
            unique case (state)
                ata_sec_pkg::ST_IDLE: ;
                ata_sec_pkg::ST_VREQ:
                begin
                    sector_check_req <= 1'b1;
                    sector_check_lba <= lba;
                    state            <= ata_sec_pkg::ST_VWAIT;
                end
                ata_sec_pkg::ST_VWAIT:
                begin
                    if (sector_check_done)
                    begin
                        if (sector_check_bad)
                        begin
                            err          <= 1'b1;
                            sector_count <= remain[15:0];
                            done_pulse   <= 1'b1;
                            state        <= ata_sec_pkg::ST_IDLE;
                        end
                        else if (remain == 17'h0_0001)
                        begin
                            done_pulse <= 1'b1;
                            state      <= ata_sec_pkg::ST_IDLE;
                        end
                        else
                        begin
                            lba_low  <= {next_lba[31:24], next_lba[7:0]};
                            lba_mid  <= {next_lba[39:32], next_lba[15:8]};
                            lba_high <= {next_lba[47:40], next_lba[23:16]};
                            remain   <= remain - 17'h0_0001;
                            state    <= ata_sec_pkg::ST_VREQ;
                        end
                    end
                end
                ata_sec_pkg::ST_DATA:
                begin
                    if (wr && (paddr == ata_sec_pkg::OFS_DATA))
                    begin
                        if (widx == 8'h00)
                            ctrl_word <= pwdata[15:0];
                        widx <= widx + 8'h01;
                        if (widx == 8'(ata_sec_pkg::SECTOR_WORDS - 1))
                            state <= ata_sec_pkg::ST_EXEC;
                    end
                end
                ata_sec_pkg::ST_EXEC:
                begin
                    err        <= !exec_ok;
                    erase_req  <= exec_ok && (cmd == ata_sec_pkg::CMD_ERASE_UNIT);
                    done_pulse <= 1'b1;
                    state      <= ata_sec_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Password words captured as they stream in
    always_ff @(posedge pclk)
    begin
        if ((state == ata_sec_pkg::ST_DATA) && wr && (paddr == ata_sec_pkg::OFS_DATA)
            && (widx >= 8'h01) && (widx <= 8'(ata_sec_pkg::PW_WORDS)))
            pw_buf[widx[3:0] - 4'h1] <= pwdata[15:0];
    end

    // Stored passwords model flash and survive presetn
    always_ff @(posedge pclk)
    begin
        if ((state == ata_sec_pkg::ST_EXEC) && (cmd == ata_sec_pkg::CMD_SET_PW))
        begin
            for (int i = 0; i < ata_sec_pkg::PW_WORDS; i++)
            begin
                if (ctrl_word[ata_sec_pkg::CTRL_ID_BIT])
                    master_pw[i] <= pw_buf[i];
                else
                    user_pw[i] <= pw_buf[i];
            end
        end
    end

    always_ff @(posedge pclk or negedge nv_init_n)
    begin
        if (!nv_init_n)
        begin
            user_pw_set <= 1'b0;
            level_max   <= 1'b0;
        end
        else if ((state == ata_sec_pkg::ST_EXEC) && exec_ok)
        begin
            if (cmd == ata_sec_pkg::CMD_SET_PW && !ctrl_word[ata_sec_pkg::CTRL_ID_BIT])
            begin
                user_pw_set <= 1'b1;
                level_max   <= ctrl_word[ata_sec_pkg::CTRL_LEVEL_BIT];
            end
            else if (cmd != ata_sec_pkg::CMD_SET_PW)
                user_pw_set <= 1'b0;
        end
    end

    // Lock is armed one cycle after reset release, never from a port under reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rst_seen <= 1'b0;
            locked   <= 1'b0;
            frozen   <= 1'b0;
        end
        else
        begin
            rst_seen <= 1'b1;
            if (!rst_seen)
                locked <= user_pw_set;
            else if ((state == ata_sec_pkg::ST_EXEC) && exec_ok && (cmd != ata_sec_pkg::CMD_SET_PW))
                locked <= 1'b0;
            if (cmd_go && (code == ata_sec_pkg::CMD_FREEZE) && sec_sup)
                frozen <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sec_sup <= ata_sec_pkg::CFG_SEC_SUP_RST;
        else if (wr && (paddr == ata_sec_pkg::OFS_CONFIG))
            sec_sup <= pwdata[ata_sec_pkg::CFG_SEC_SUP_BIT];
    end
    // Interrupt: set beats the clear by status read or new command
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            intrq <= 1'b0;
        else if (done_pulse)
            intrq <= 1'b1;
        else if (cmd_go || (rd && (paddr == ata_sec_pkg::OFS_STATUS)))
            intrq <= 1'b0;
    end
    sequence s_verify_pass;
        (state == ata_sec_pkg::ST_VWAIT) && sector_check_done && !sector_check_bad
        && (remain == 17'h0_0001);
    endsequence
    sequence s_verify_fail;
        (state == ata_sec_pkg::ST_VWAIT) && sector_check_done && sector_check_bad;
    endsequence
    AST_VERIFY_NO_DRQ: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go && (code == ata_sec_pkg::CMD_VERIFY_EXT) |=> status.bsy && !status.drq [*2])
        else $error("verify raised data request or dropped busy");
    AST_VERIFY_DONE_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
        s_verify_pass |=> (state == ata_sec_pkg::ST_IDLE) ##1 intrq)
        else $error("verify completion missed idle or interrupt");
    AST_VERIFY_LAST_LBA: assert property (@(posedge pclk) disable iff (!presetn)
        s_verify_pass |=> (lba == $past(sector_check_lba)))
        else $error("address registers not at last verified sector");
    AST_VERIFY_ERR_LBA: assert property (@(posedge pclk) disable iff (!presetn)
        s_verify_fail |=> err && (lba == $past(sector_check_lba)))
        else $error("failing sector address not kept");
    AST_VERIFY_ERR_COUNT: assert property (@(posedge pclk) disable iff (!presetn)
        s_verify_fail |=> (sector_count == 16'($past(remain))))
        else $error("sector count not loaded with remaining sectors");
    AST_NOP_DONE: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go && is_nop |=> !err && $stable(lba) && (state == ata_sec_pkg::ST_IDLE) ##1 intrq)
        else $error("no-op command misbehaved");
    AST_ERASE_NEEDS_PREP: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go && (code == ata_sec_pkg::CMD_ERASE_UNIT) && !prepared
        |=> err && (state == ata_sec_pkg::ST_IDLE) ##1 !erase_req)
        else $error("erase unit ran without prepare");
    AST_FROZEN_REJECT: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go && frozen && sec_cmd |=> err && (state == ata_sec_pkg::ST_IDLE))
        else $error("frozen device accepted a lock command");
    AST_FROZEN_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
        frozen |=> frozen)
        else $error("frozen cleared without reset");
    AST_FREEZE_COUNT: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go && (code == ata_sec_pkg::CMD_FREEZE) && sec_sup
        |=> frozen && (sector_count == 16'h0000) && !wear_level_req)
        else $error("freeze did not zero count or set frozen");
    AST_WEAR_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go && (code == ata_sec_pkg::CMD_FREEZE) && !sec_sup |=> wear_level_req && !frozen)
        else $error("freeze code not mapped to wear level");
    AST_PW_HANDSHAKE: assert property (@(posedge pclk) disable iff (!presetn)
        (state == ata_sec_pkg::ST_EXEC) |-> status.bsy && !status.drq ##1 done_pulse ##1 intrq)
        else $error("password sector completion handshake wrong");
endmodule : ata_verify_security_cmds
`default_nettype wire

// file: verif/media_model.sv
/* Media checker model: one done pulse per check request, prompt or slow in turn.
   Assumes one request at a time; bad is only meaningful with done. */
`timescale 1ns/1ps
`default_nettype none
module media_model
(
    input  wire logic        clk,
    input  wire logic        req,
    input  wire logic [47:0] lba,
    input  wire logic [47:0] bad_lba,
    input  wire logic        bad_en,
    output logic             done,
    output logic             bad
);
    logic [2:0] cnt  = 3'h0;
    logic       slow = 1'b0;
    logic       hit  = 1'b0;
    // Between answers bad toggles so a stale value is never mistaken for valid
    always_ff @(posedge clk)
    begin
        done <= 1'b0;
        bad  <= ~bad;
        if (req)
        begin
            cnt  <= slow ? 3'h5 : 3'h1;
            slow <= ~slow;
            hit  <= bad_en && (lba == bad_lba);
        end
        else if (cnt == 3'h1)
        begin
            done <= 1'b1;
            bad  <= hit;
        end
        if (!req && cnt != 3'h0)
            cnt <= cnt - 3'h1;
    end
endmodule : media_model
`default_nettype wire

// file: verif/test_ata_verify_security_cmds.sv
/* Self-checking bench: APB host tasks, media model, queued read expectations.
   Assumes the package and the media model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module test_ata_verify_security_cmds;
    logic        pclk = 1'b0, presetn, nv_init_n, psel, penable, pwrite, bad_en;
    logic        pready, pslverr, intrq, sreq, sdone, sbad, erase_req, wear;
    logic [7:0]  paddr;
    logic [15:0] ctl = 16'h0000;
    logic [31:0] pwdata, prdata, rs = 32'h0ca10be2;
    logic [47:0] slba, bad_lba, s;
    logic [32:0] exp_q[$], e;
    int          err_count = 0, tests_run = 0, n_erase = 0, n_wear = 0;
    always #10 pclk = ~pclk;
    ata_verify_security_cmds dut_u (.pclk(pclk), .presetn(presetn), .nv_init_n(nv_init_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .intrq(intrq),
        .sector_check_req(sreq), .sector_check_lba(slba), .sector_check_done(sdone),
        .sector_check_bad(sbad), .erase_req(erase_req), .wear_level_req(wear));
    media_model part_u (.clk(pclk), .req(sreq), .lba(slba), .bad_lba(bad_lba),
        .bad_en(bad_en), .done(sdone), .bad(sbad));
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [32:0] x);
        exp_q.push_back(x);
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic lba(input logic [47:0] l, input bit chk);
        for (int i = 0; i < 3; i++)
        begin
            if (chk)
                rd(ata_sec_pkg::OFS_LBA_LOW + 8'(4 * i), {17'h0, l[8*i+24 +: 8], l[8*i +: 8]});
            else
            begin
                apb(1'b1, ata_sec_pkg::OFS_LBA_LOW + 8'(4 * i), {24'h0, l[8*i+24 +: 8]});
                apb(1'b1, ata_sec_pkg::OFS_LBA_LOW + 8'(4 * i), {24'h0, l[8*i +: 8]});
            end
        end
    endtask : lba
    task automatic run(input logic [7:0] c, input bit sec, input logic [15:0] k,
                       input logic [7:0] st);
        int n;
        apb(1'b1, ata_sec_pkg::OFS_COMMAND, {24'h0, c});
        for (int i = 0; sec && i < ata_sec_pkg::SECTOR_WORDS; i++)
            apb(1'b1, ata_sec_pkg::OFS_DATA,
                {16'h0, i == 0 ? ctl : (i < 17 ? k + 16'(i) : 16'h0)});
        for (n = 0; n < 3000 && intrq !== 1'b1; n++)
            @(posedge pclk);
        if (n == 3000)
        begin
            err_count++;
            $display("BAD %0t no completion for %h", $time, c);
        end
        rd(ata_sec_pkg::OFS_STATUS, {25'h0, st});
    endtask : run
    always @(posedge pclk)
    begin
        if (erase_req === 1'b1)
            n_erase++;
        if (wear === 1'b1)
            n_wear++;
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            e = exp_q.pop_front();
            tests_run++;
            if ({pslverr, prdata} !== e)
            begin
                err_count++;
                $display("BAD %0t read %h expected %h", $time, {pslverr, prdata}, e);
            end
        end
    end
    task automatic complete_run;
        $display("compares %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run
    initial
    begin
        #1000000;
        err_count++;
        complete_run();
    end
    initial
    begin
        {presetn, nv_init_n, psel, penable, pwrite, bad_en} = 6'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        bad_lba = 48'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        nv_init_n <= 1'b1;
        rs = lfsr(rs);
        s[47:16] = rs;
        rs = lfsr(rs);
        s[15:0] = rs[15:0];
        lba(s, 0);
        apb(1'b1, ata_sec_pkg::OFS_SECTOR_CNT, 32'h0);
        apb(1'b1, ata_sec_pkg::OFS_SECTOR_CNT, 32'h3);
        run(ata_sec_pkg::CMD_VERIFY_EXT, 0, 16'h0, 8'h00);
        lba(s + 48'h2, 1);
        bad_lba <= s + 48'h1;
        bad_en <= 1'b1;
        lba(s, 0);
        apb(1'b1, ata_sec_pkg::OFS_SECTOR_CNT, 32'h0);
        apb(1'b1, ata_sec_pkg::OFS_SECTOR_CNT, 32'h3);
        run(ata_sec_pkg::CMD_VERIFY_EXT, 0, 16'h0, 8'h01);
        lba(s + 48'h1, 1);
        rd(ata_sec_pkg::OFS_SECTOR_CNT, 33'h2);
        $display("test verify done");
        for (int c = 8'h10; c < 8'h20; c += 5)
            run(8'(c), 0, 16'h0, 8'h00);
        run(ata_sec_pkg::CMD_ERASE_UNIT, 0, 16'h0, 8'h01);
        run(ata_sec_pkg::CMD_SET_PW, 1, rs[15:0], 8'h10);
        run(ata_sec_pkg::CMD_ERASE_PREP, 0, 16'h0, 8'h10);
        run(ata_sec_pkg::CMD_ERASE_UNIT, 1, ~rs[15:0], 8'h11);
        run(ata_sec_pkg::CMD_ERASE_PREP, 0, 16'h0, 8'h10);
        run(ata_sec_pkg::CMD_ERASE_UNIT, 1, rs[15:0], 8'h00);
        tests_run++;
        if (n_erase != 1)
        begin
            err_count++;
            $display("BAD %0t erase pulses %0d", $time, n_erase);
        end
        ctl = 16'h0001;
        run(ata_sec_pkg::CMD_SET_PW, 1, rs[31:16], 8'h00);
        ctl = 16'h0100;
        run(ata_sec_pkg::CMD_SET_PW, 1, rs[15:0], 8'h18);
        ctl = 16'h0001;
        run(ata_sec_pkg::CMD_DISABLE_PW, 1, rs[31:16], 8'h19);
        ctl = 16'h0000;
        run(ata_sec_pkg::CMD_SET_PW, 1, rs[15:0], 8'h10);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(ata_sec_pkg::OFS_STATUS, 33'h30);
        ctl = 16'h0001;
        run(ata_sec_pkg::CMD_DISABLE_PW, 1, rs[31:16], 8'h00);
        ctl = 16'h0000;
        $display("test password done");
        apb(1'b1, ata_sec_pkg::OFS_SECTOR_CNT, 32'h5);
        run(ata_sec_pkg::CMD_FREEZE, 0, 16'h0, 8'h40);
        rd(ata_sec_pkg::OFS_SECTOR_CNT, 33'h0);
        run(ata_sec_pkg::CMD_FREEZE, 0, 16'h0, 8'h40);
        run(ata_sec_pkg::CMD_DISABLE_PW, 0, 16'h0, 8'h41);
        rd(8'h20, {1'b1, 32'h0});
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(ata_sec_pkg::OFS_STATUS, 33'h0);
        apb(1'b1, ata_sec_pkg::OFS_CONFIG, 32'h0);
        rd(ata_sec_pkg::OFS_CONFIG, 33'h0);
        run(ata_sec_pkg::CMD_FREEZE, 0, 16'h0, 8'h00);
        tests_run++;
        if (n_wear != 1)
        begin
            err_count++;
            $display("BAD %0t wear pulses %0d", $time, n_wear);
        end
        $display("test freeze done");
        complete_run();
    end
endmodule : test_ata_verify_security_cmds
`default_nettype wire
